// file: uart_irq_pkg.sv
// Constants for the channel interrupt mask and status block.
// Assumes one channel clock and an eight-bit host register port.
`default_nettype none
package uart_irq_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_RHR    = 3'h0;
    localparam logic [2:0] ADDR_MASK   = 3'h1;
    localparam logic [2:0] ADDR_SRC    = 3'h2;
    localparam logic [2:0] ADDR_LSR    = 3'h5;
    localparam logic [2:0] ADDR_RES2   = 3'h5;
    localparam logic [2:0] ADDR_PAUSE1 = 3'h6;
    localparam logic [2:0] ADDR_PAUSE2 = 3'h7;
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
    localparam int         LCR_DLAB    = 7;
    localparam int         EFR_ENH     = 4;
    localparam int         EFR_AUTORTS = 6;
    // ------------------------------------------------------------
    // Mask bits, reset values
    // ------------------------------------------------------------
    localparam int MSK_RX    = 0;
    localparam int MSK_TX    = 1;
    localparam int MSK_LS    = 2;
    localparam int MSK_MS    = 3;
    localparam int MSK_SLEEP = 4;
    localparam int MSK_PAUSE = 5;
    localparam int MSK_RTS   = 6;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CHAR_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    // ------------------------------------------------------------
    // Source codes, bus sampling
    // ------------------------------------------------------------
    localparam logic [5:0] SRC_NONE  = 6'h01;
    localparam logic [5:0] SRC_LS    = 6'h06;
    localparam logic [5:0] SRC_RX    = 6'h04;
    localparam logic [5:0] SRC_TX    = 6'h02;
    localparam logic [5:0] SRC_MS    = 6'h00;
    localparam logic [5:0] SRC_PAUSE = 6'h10;
    localparam logic [5:0] SRC_RTS   = 6'h20;
    localparam int          ERR_W     = 3;
    localparam int          ENT_W     = 11;
    localparam int          BUF_DEPTH = 2;
    localparam logic [14:0] SYNC_IDLE = 15'h7fff;
endpackage
`default_nettype wire

// file: uart_irq_status.sv
// Interrupt mask, source and line status logic of one channel.
// Assumes FIFO levels and channel events arrive on CLK_SYS; the
// host strobes and address are asynchronous pins.
//
// Functional notes
// - Receive interrupt at trigger, withdrawn below it
// - Source code and interrupt clear together
// - Data ready sets on push, clears when empty
// - Overrun flag marks FIFO data suspect
// - Error bits follow held character only
// - Holding empty and all transmit empty bits
// - Global error while any stored char errored
// - Receive interrupt per FIFO or single mode
// - Transmit ready interrupt per mode
// - Enabling with empty holding interrupts at once
// - Line status interrupt on overrun or any held error bit, not global error
// - Overrun now, others at holding position
// - Modem mask gates modem change interrupt
// - Sleep permit only with enhanced mode
// - Pause character interrupt with enhanced mode
// - Interrupt on request-to-send rising
// - All mask bits reset to zero
// - Enabled sources reported through source register
// - Upper mask bits hidden without enhanced mode
`timescale 1ns/100ps
`default_nettype none
module uart_irq_status (
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic [2:0] BUS_ADDR,
    input  wire logic       BUS_CS_N,
    input  wire logic       BUS_RD_N,
    input  wire logic       BUS_WR_N,
    input  wire logic [7:0] BUS_DATA_IN,
    output logic      [7:0] BUS_DATA_OUT,
    output logic            BUS_DATA_OE_N,
    input  wire logic       FIFO_SUMMARY_SELECT_N,
    input  wire logic [7:0] LINE_CTRL,
    input  wire logic [7:0] ENH_FEATURE,
    input  wire logic       FIFO_ENABLE,
    input  wire logic [6:0] RX_LEVEL,
    input  wire logic [6:0] RX_TRIGGER,
    input  wire logic       RX_FIFO_ERR,
    input  wire logic [7:0] RX_CHAR,
    input  wire logic [2:0] RX_CHAR_ERR,
    input  wire logic       RX_CHAR_VALID,
    output logic            RX_CHAR_READY,
    input  wire logic       RX_OVERRUN,
    input  wire logic [6:0] TX_LEVEL,
    input  wire logic [6:0] TX_TRIGGER,
    input  wire logic       TX_SHIFT_EMPTY,
    input  wire logic       MODEM_DELTA,
    input  wire logic       PAUSE_RCVD,
    input  wire logic       RTS_N_LEVEL,
    input  wire logic [2:0] OTHER_RX_READY_N,
    input  wire logic [2:0] OTHER_TX_READY_N,
    output logic            RX_READY_CHAN_A_N,
    output logic            TX_READY_CHAN_A_N,
    output logic            SLEEP_PERMIT,
    output logic            INT
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [14:0] sync_a, sync_b, sync_c;
    // Whole bus vector sampled twice; only sync_b onward is decoded
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            sync_a <= uart_irq_pkg::SYNC_IDLE;
            sync_b <= uart_irq_pkg::SYNC_IDLE;
            sync_c <= uart_irq_pkg::SYNC_IDLE;
        end
        else
        begin
            sync_a <= {BUS_CS_N, BUS_RD_N, BUS_WR_N,
                       FIFO_SUMMARY_SELECT_N, BUS_ADDR, BUS_DATA_IN};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    logic       cs_n, rd_n, wr_n, sel_n;
    logic [2:0] addr;
    logic [7:0] wdat;
    logic       rd_start, wr_start, reg_rd;
    // Strobe edges; data is taken at the write's leading edge
    assign {cs_n, rd_n, wr_n, sel_n, addr, wdat} = sync_b;
    assign rd_start = !rd_n && sync_c[13] && (!cs_n || !sel_n);
    assign wr_start = !wr_n && sync_c[12] && !cs_n;
    assign reg_rd   = rd_start && sel_n;
    // Ordinary bank: divisor latch off
    function automatic logic is_std(input logic [2:0] a, input logic [2:0] t,
                                    input logic [7:0] lcr);
        is_std = (a == t) && !lcr[uart_irq_pkg::LCR_DLAB];
    endfunction
    // Flow character bank: key value in line control
    function automatic logic is_chr(input logic [2:0] a, input logic [2:0] t,
                                    input logic [7:0] lcr);
        is_chr = (a == t) && (lcr == uart_irq_pkg::LCR_ENH_KEY);
    endfunction
    logic efr_on;
    assign efr_on = ENH_FEATURE[uart_irq_pkg::EFR_ENH];
    // ------------------------------------------------------------
    // Mask and flow character registers
    // ------------------------------------------------------------
    logic [7:0] mask, resume2, pause1, pause2;
    // Upper half is locked while enhanced mode is off
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            mask <= uart_irq_pkg::MASK_RESET;
        else if (wr_start && is_std(addr, uart_irq_pkg::ADDR_MASK, LINE_CTRL))
            mask <= efr_on ? wdat : {mask[7:4], wdat[3:0]};
    end
    // Flow control characters, stored for the flow logic
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            resume2 <= uart_irq_pkg::CHAR_RESET;
            pause1  <= uart_irq_pkg::CHAR_RESET;
            pause2  <= uart_irq_pkg::CHAR_RESET;
        end
        else if (wr_start)
        begin
            if (is_chr(addr, uart_irq_pkg::ADDR_RES2, LINE_CTRL))
                resume2 <= wdat;
            if (is_chr(addr, uart_irq_pkg::ADDR_PAUSE1, LINE_CTRL))
                pause1 <= wdat;
            if (is_chr(addr, uart_irq_pkg::ADDR_PAUSE2, LINE_CTRL))
                pause2 <= wdat;
        end
    end
    // ------------------------------------------------------------
    // Two-entry holding buffer
    // ------------------------------------------------------------
    logic [uart_irq_pkg::ENT_W-1:0] buf_ent [uart_irq_pkg::BUF_DEPTH];
    logic [1:0] count;
    logic       push, pop, wr_idx;
    assign RX_CHAR_READY = (count != 2'h2); // Stalls the FIFO when full
    assign push   = RX_CHAR_VALID && RX_CHAR_READY;
    assign pop    = reg_rd && (count != 2'h0)
                    && is_std(addr, uart_irq_pkg::ADDR_RHR, LINE_CTRL);
    assign wr_idx = pop ? count[1] : count[0];
    // Entry 0 is the holding position; a pop shifts entry 1 down
    genvar gi;
    generate
        for (gi = 0; gi < uart_irq_pkg::BUF_DEPTH; gi++)
        begin : g_ent
            always_ff @(posedge CLK_SYS or posedge RST)
            begin
                if (RST)
                    buf_ent[gi] <= '0;
                else if (push && (wr_idx == 1'(gi)))
                    buf_ent[gi] <= {RX_CHAR_ERR, RX_CHAR};
                else if (pop && (gi < uart_irq_pkg::BUF_DEPTH - 1))
                    buf_ent[gi] <= buf_ent[(gi + 1) % uart_irq_pkg::BUF_DEPTH];
            end
        end
    endgenerate
    // Occupancy
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            count <= 2'h0;
        else
            count <= count + {1'b0, push} - {1'b0, pop};
    end
    // ------------------------------------------------------------
    // Sticky event flags
    // ------------------------------------------------------------
    logic overrun, pause_flag, rts_flag, rts_prev;
    logic lsr_rd, src_rd;
    assign lsr_rd = reg_rd && is_std(addr, uart_irq_pkg::ADDR_LSR, LINE_CTRL);
    assign src_rd = reg_rd && is_std(addr, uart_irq_pkg::ADDR_SRC, LINE_CTRL);
    // A new event in the clearing read's cycle wins
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            overrun <= 1'b0;
        else if (RX_OVERRUN)
            overrun <= 1'b1;
        else if (lsr_rd)
            overrun <= 1'b0;
    end
    // Pause character seen
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            pause_flag <= 1'b0;
        else if (PAUSE_RCVD)
            pause_flag <= 1'b1;
        else if (src_rd)
            pause_flag <= 1'b0;
    end
    // Request-to-send low to high, only under automatic control
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            rts_prev <= 1'b1; // Pin idles high, so no false rise after reset
            rts_flag <= 1'b0;
        end
        else
        begin
            rts_prev <= RTS_N_LEVEL;
            if (RTS_N_LEVEL && !rts_prev && ENH_FEATURE[uart_irq_pkg::EFR_AUTORTS])
                rts_flag <= 1'b1;
            else if (src_rd)
                rts_flag <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Line status and conditions
    // ------------------------------------------------------------
    logic [2:0] head_err;
    logic [7:0] line_status_reg, rx_fill;
    logic       trig_hit, thr_empty, rx_cond, tx_cond, ls_cond, held_err;
    // Error bits belong to the holding position only; global error sees both entries
    assign head_err  = (count != 2'h0) ? buf_ent[0][10:8] : 3'h0;
    assign held_err  = ((count != 2'h0) && (buf_ent[0][10:8] != 3'h0))
                       || ((count == 2'h2) && (buf_ent[1][10:8] != 3'h0));
    assign thr_empty = (TX_LEVEL == 7'h00);
    assign rx_fill   = {1'b0, RX_LEVEL} + {6'h00, count};
    assign trig_hit  = rx_fill >= {1'b0, RX_TRIGGER};
    assign line_status_reg[0]    = (count != 2'h0) || (RX_LEVEL != 7'h00);
    assign line_status_reg[1]    = overrun;
    assign line_status_reg[4:2]  = head_err;
    assign line_status_reg[5]    = thr_empty;
    assign line_status_reg[6]    = thr_empty && TX_SHIFT_EMPTY;
    assign line_status_reg[7]    = RX_FIFO_ERR || held_err;
    // Per-mode raw conditions; level based, so enabling the mask
    // over an already empty holding register interrupts at once
    assign rx_cond = FIFO_ENABLE ? trig_hit : line_status_reg[0];
    assign tx_cond = FIFO_ENABLE ? (TX_LEVEL < TX_TRIGGER) : thr_empty;
    assign ls_cond = overrun || (head_err != 3'h0);
    // ------------------------------------------------------------
    // Source priority
    // ------------------------------------------------------------
    logic [5:0] src_code;
    logic       any_pend;
    // Highest first: line, receive, transmit, modem, pause, rts
    always_comb
    begin
        any_pend = 1'b1;
        if (mask[uart_irq_pkg::MSK_LS] && ls_cond)
            src_code = uart_irq_pkg::SRC_LS;
        else if (mask[uart_irq_pkg::MSK_RX] && rx_cond)
            src_code = uart_irq_pkg::SRC_RX;
        else if (mask[uart_irq_pkg::MSK_TX] && tx_cond)
            src_code = uart_irq_pkg::SRC_TX;
        else if (mask[uart_irq_pkg::MSK_MS] && MODEM_DELTA)
            src_code = uart_irq_pkg::SRC_MS;
        else if (efr_on && mask[uart_irq_pkg::MSK_PAUSE] && pause_flag)
            src_code = uart_irq_pkg::SRC_PAUSE;
        else if (efr_on && mask[uart_irq_pkg::MSK_RTS] && rts_flag)
            src_code = uart_irq_pkg::SRC_RTS;
        else
        begin
            src_code = uart_irq_pkg::SRC_NONE;
            any_pend = 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Read data and registered outputs
    // ------------------------------------------------------------
    logic [7:0] next_rdata, mask_view;
    assign mask_view = efr_on ? mask : {4'h0, mask[3:0]};
    // Summary read ignores address and bank entirely
    always_comb
    begin
        next_rdata = uart_irq_pkg::ZERO_BYTE;
        if (!sel_n)
            next_rdata = {OTHER_RX_READY_N, !rx_cond,
                          OTHER_TX_READY_N, !tx_cond};
        else if (is_chr(addr, uart_irq_pkg::ADDR_RES2, LINE_CTRL))
            next_rdata = resume2;
        else if (is_chr(addr, uart_irq_pkg::ADDR_PAUSE1, LINE_CTRL))
            next_rdata = pause1;
        else if (is_chr(addr, uart_irq_pkg::ADDR_PAUSE2, LINE_CTRL))
            next_rdata = pause2;
        else if (is_std(addr, uart_irq_pkg::ADDR_RHR, LINE_CTRL))
            next_rdata = buf_ent[0][7:0];
        else if (is_std(addr, uart_irq_pkg::ADDR_MASK, LINE_CTRL))
            next_rdata = mask_view;
        else if (is_std(addr, uart_irq_pkg::ADDR_SRC, LINE_CTRL))
            next_rdata = {FIFO_ENABLE, FIFO_ENABLE, src_code};
        else if (is_std(addr, uart_irq_pkg::ADDR_LSR, LINE_CTRL))
            next_rdata = line_status_reg;
    end
    // Data captured at the read's leading edge, held to its end
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            BUS_DATA_OUT  <= uart_irq_pkg::ZERO_BYTE;
            BUS_DATA_OE_N <= 1'b1;
        end
        else
        begin
            if (rd_start)
                BUS_DATA_OUT <= next_rdata;
            BUS_DATA_OE_N <= !(!rd_n && (!cs_n || !sel_n));
        end
    end
    // Interrupt, sleep permit and channel ready pins
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            INT               <= 1'b0;
            SLEEP_PERMIT      <= 1'b0;
            RX_READY_CHAN_A_N <= 1'b1;
            TX_READY_CHAN_A_N <= 1'b1;
        end
        else
        begin
            INT               <= any_pend;
            SLEEP_PERMIT      <= efr_on && mask[uart_irq_pkg::MSK_SLEEP];
            RX_READY_CHAN_A_N <= !rx_cond;
            TX_READY_CHAN_A_N <= !tx_cond;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_rx_trigger: assert property (
        mask[uart_irq_pkg::MSK_RX] && FIFO_ENABLE && trig_hit |=> INT)
        else $error("receive trigger gave no interrupt");
    a_rx_withdraw: assert property (
        FIFO_ENABLE && !trig_hit |-> src_code != uart_irq_pkg::SRC_RX)
        else $error("receive source shown below trigger");
    a_ready_push: assert property (push |=> line_status_reg[0])
        else $error("data ready missing after push");
    a_overrun_set: assert property (RX_OVERRUN |=> overrun && line_status_reg[1])
        else $error("overrun flag not set");
    a_err_empty: assert property (count == 2'h0 |-> line_status_reg[4:2] == 3'h0)
        else $error("error bits with empty holding");
    a_all_empty: assert property (line_status_reg[6] |-> line_status_reg[5] && TX_SHIFT_EMPTY)
        else $error("transmit empty bits inconsistent");
    a_global_err: assert property (RX_FIFO_ERR |-> line_status_reg[7])
        else $error("global error missing");
    a_tx_ready: assert property (mask[uart_irq_pkg::MSK_TX] && tx_cond |=> INT)
        else $error("transmit ready gave no interrupt");
    a_sleep_gate: assert property (!efr_on |=> !SLEEP_PERMIT)
        else $error("sleep permitted without enhanced mode");
    a_upper_hidden: assert property (
        !pop && reg_rd && !efr_on && is_std(addr, uart_irq_pkg::ADDR_MASK, LINE_CTRL)
        |=> BUS_DATA_OUT[7:4] == 4'h0)
        else $error("upper mask bits visible");
endmodule // uart_irq_status
`default_nettype wire

// file: rx_feed.sv
// Receive FIFO side model: offers characters on valid and ready.
// Assumes the block's clock; the bench calls send for each word.
`timescale 1ns/100ps
`default_nettype none
module rx_feed (
    input  wire logic       clk,
    input  wire logic       ready,
    output logic            valid,
    output logic      [7:0] data,
    output logic      [2:0] err
);
    // Offer held until a falling edge sees ready, so next edge takes it
    task automatic send(input logic [7:0] d, input logic [2:0] e);
        @(negedge clk);
        data  = d;
        err   = e;
        valid = 1'b1;
        while (ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        valid = 1'b0;
        data  = ~d;  // Stale word never left showing
        err   = ~e;
    endtask

    // Idle at time zero
    initial
    begin
        valid = 1'b0;
        data  = 8'h00;
        err   = 3'h0;
    end
endmodule // rx_feed
`default_nettype wire

// file: tb.sv
// Testbench: host register accesses against the interrupt block.
// Assumes the design package and rx_feed are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) check(n, e, a)
module tb;
    logic       clk_sys, rst, cs_n, rd_n, wr_n, sel_n, fifo_en, use_sel;
    logic       rx_ferr, ovr, tx_sh_e, modem, pause, rts_n;
    logic       rx_valid, rx_ready, rx_a_n, tx_a_n, sleep, irq, oe_n, oe;
    logic [2:0] addr, rx_err, oth_rx, oth_tx;
    logic [6:0] rx_lvl, rx_trig, tx_lvl, tx_trig;
    logic [7:0] din, dout, lcr, enh, rx_char, v;
    int         err_count, tests_run;

    uart_irq_status uart_irq_status_inst (
        .CLK_SYS(clk_sys), .RST(rst), .BUS_ADDR(addr), .BUS_CS_N(cs_n),
        .BUS_RD_N(rd_n), .BUS_WR_N(wr_n), .BUS_DATA_IN(din),
        .BUS_DATA_OUT(dout), .BUS_DATA_OE_N(oe_n),
        .FIFO_SUMMARY_SELECT_N(sel_n), .LINE_CTRL(lcr), .ENH_FEATURE(enh),
        .FIFO_ENABLE(fifo_en), .RX_LEVEL(rx_lvl), .RX_TRIGGER(rx_trig),
        .RX_FIFO_ERR(rx_ferr), .RX_CHAR(rx_char), .RX_CHAR_ERR(rx_err),
        .RX_CHAR_VALID(rx_valid), .RX_CHAR_READY(rx_ready),
        .RX_OVERRUN(ovr), .TX_LEVEL(tx_lvl), .TX_TRIGGER(tx_trig),
        .TX_SHIFT_EMPTY(tx_sh_e), .MODEM_DELTA(modem), .PAUSE_RCVD(pause),
        .RTS_N_LEVEL(rts_n), .OTHER_RX_READY_N(oth_rx),
        .OTHER_TX_READY_N(oth_tx), .RX_READY_CHAN_A_N(rx_a_n),
        .TX_READY_CHAN_A_N(tx_a_n), .SLEEP_PERMIT(sleep), .INT(irq));

    rx_feed rx_feed_inst (.clk(clk_sys), .ready(rx_ready), .valid(rx_valid),
        .data(rx_char), .err(rx_err));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] a);
        tests_run++;
        if (a !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, a);
        end
    endtask

    // Strobes held 4 clocks, idle 4, well past the 3-clock minimum
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        din  = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        wr_n = 1'b1;
        cs_n = 1'b1;
        din  = ~d;
        repeat (4) @(negedge clk_sys);
    endtask

    // Data held after the strobe, so it is taken just before release
    task automatic rc(input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] e, input string n);
        @(negedge clk_sys);
        addr  = a;
        cs_n  = use_sel;
        sel_n = !use_sel;
        rd_n  = 1'b0;
        repeat (5) @(negedge clk_sys);
        v     = dout;
        oe    = oe_n;
        rd_n  = 1'b1;
        cs_n  = 1'b1;
        sel_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK(n, e, v & m);
        `CHK("oe drive then release", 8'h01, {6'h0, oe, oe_n});
    endtask

    task automatic ibit(input logic e, input string n);
        repeat (4) @(negedge clk_sys);
        `CHK(n, {7'h0, e}, {7'h0, irq});
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Clock, 4 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Watchdog far beyond the several hundred cycles the run needs
    initial
    begin
        #200000;
        err_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {cs_n, rd_n, wr_n, sel_n, fifo_en, tx_sh_e} = 6'h3f;
        {use_sel, rx_ferr, ovr, modem, pause, rts_n} = 6'h00;
        {addr, din, lcr, enh} = 27'h0;
        {oth_rx, oth_tx, rx_lvl, tx_lvl} = 20'h0;
        rx_trig = 7'h7f;
        tx_trig = 7'h08;
        err_count = 0;
        tests_run = 0;
        rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        // Polled mode: FIFO on, mask clear, status read directly
        rc(3'h1, 8'hff, 8'h00, "mask rst");
        ibit(1'b0, "int rst");
        rc(3'h5, 8'h61, 8'h60, "lsr tx empty");
        tx_sh_e = 1'b0;
        rc(3'h5, 8'h60, 8'h20, "lsr shift busy");
        tx_lvl = 7'h0a;
        // Upper mask bits and sleep permit need enhanced mode
        wr(3'h1, 8'hf0);
        rc(3'h1, 8'hff, 8'h00, "mask hidden");
        enh = 8'h50;
        wr(3'h1, 8'h10);
        rc(3'h1, 8'hff, 8'h10, "mask upper");
        `CHK("sleep on", 8'h01, {7'h0, sleep});
        enh = 8'h00;
        rc(3'h1, 8'hff, 8'h00, "mask lock");
        ibit(1'b0, "int lock");
        `CHK("sleep off", 8'h00, {7'h0, sleep});
        // Pause character and request-to-send rising
        enh = 8'h50;
        wr(3'h1, 8'h20);
        @(negedge clk_sys);
        pause = 1'b1;
        @(negedge clk_sys);
        pause = 1'b0;
        ibit(1'b1, "int pause");
        rc(3'h2, 8'hff, 8'hd0, "src pause");
        rc(3'h2, 8'hff, 8'hc1, "src none");
        wr(3'h1, 8'h40);
        rts_n = 1'b1;
        ibit(1'b1, "int rts");
        rc(3'h2, 8'hff, 8'he0, "src rts");
        ibit(1'b0, "int rts clr");
        // Transmit ready below trigger, and enable while empty
        wr(3'h1, 8'h02);
        ibit(1'b0, "int tx full");
        tx_lvl = 7'h04;
        ibit(1'b1, "int tx low");
        `CHK("tx pin low", 8'h00, {7'h0, tx_a_n});
        rc(3'h2, 8'hff, 8'hc2, "src tx");
        wr(3'h1, 8'h00);
        tx_lvl = 7'h00;
        ibit(1'b0, "int masked");
        wr(3'h1, 8'h02);
        `CHK("int tx en", 8'h01, {7'h0, irq});
        tx_lvl = 7'h0a;
        // Modem change gated by its mask bit
        modem = 1'b1;
        ibit(1'b0, "int modem off");
        wr(3'h1, 8'h08);
        ibit(1'b1, "int modem on");
        rc(3'h2, 8'hff, 8'hc0, "src modem");
        wr(3'h1, 8'h01);
        modem = 1'b0;
        // Three words into a two-entry buffer: third stalls, none lost
        rx_trig = 7'h02;
        fork
            begin
                rx_feed_inst.send(8'h51, 3'h0);
                rx_feed_inst.send(8'h52, 3'h0);
                rx_feed_inst.send(8'h53, 3'h0);
            end
        join_none
        repeat (20) @(negedge clk_sys);
        `CHK("buf full", 8'h00, {7'h0, rx_ready});
        ibit(1'b1, "int rx trig");
        `CHK("rx pin trig", 8'h00, {7'h0, rx_a_n});
        rc(3'h2, 8'hff, 8'hc4, "src rx");
        rc(3'h5, 8'h01, 8'h01, "lsr ready");
        rc(3'h0, 8'hff, 8'h51, "pop 1");
        rc(3'h0, 8'hff, 8'h52, "pop 2");
        ibit(1'b0, "int rx below");
        rc(3'h2, 8'hff, 8'hc1, "src rx clr");
        rc(3'h5, 8'h01, 8'h01, "lsr one left");
        rc(3'h0, 8'hff, 8'h53, "pop 3");
        rc(3'h5, 8'h01, 8'h00, "lsr empty");
        // Single-character mode: one held char interrupts
        fifo_en = 1'b0;
        tx_lvl = 7'h04;
        rx_feed_inst.send(8'h60, 3'h0);
        ibit(1'b1, "int rx single");
        `CHK("tx pin single", 8'h01, {7'h0, tx_a_n});
        rc(3'h2, 8'hff, 8'h04, "src single");
        rc(3'h0, 8'hff, 8'h60, "pop single");
        fifo_en = 1'b1;
        tx_lvl = 7'h0a;
        // Errored character at the head, then an overrun
        wr(3'h1, 8'h04);
        rx_feed_inst.send(8'h70, 3'h1);
        rc(3'h5, 8'h1c, 8'h04, "lsr parity");
        ibit(1'b1, "int line err");
        rc(3'h2, 8'hff, 8'hc6, "src line");
        rc(3'h0, 8'hff, 8'h70, "pop err");
        rc(3'h5, 8'h1c, 8'h00, "lsr clean");
        ibit(1'b0, "int line clr");
        @(negedge clk_sys);
        ovr = 1'b1;
        @(negedge clk_sys);
        ovr = 1'b0;
        ibit(1'b1, "int overrun");
        rc(3'h5, 8'h02, 8'h02, "lsr overrun");
        rc(3'h5, 8'h02, 8'h00, "lsr ovr clr");
        rx_ferr = 1'b1;
        rc(3'h5, 8'h80, 8'h80, "lsr global");
        rx_ferr = 1'b0;
        rc(3'h5, 8'h80, 8'h00, "lsr global clr");
        // Flow characters: reset value, write, readback, locked bank
        lcr = 8'hbf;
        for (int a = 5; a < 8; a++)
        begin
            rc(3'(a), 8'hff, 8'h00, "char rst");
            wr(3'(a), 8'ha0 + 8'(a));
            rc(3'(a), 8'hff, 8'ha0 + 8'(a), "char rw");
        end
        lcr = 8'h00;
        wr(3'h6, 8'h33);
        rc(3'h3, 8'hff, 8'h00, "unmapped");
        lcr = 8'hbf;
        rc(3'h6, 8'hff, 8'ha6, "char locked");
        lcr = 8'h00;
        // Summary read with chip select idle and odd address
        oth_rx = 3'b101;
        oth_tx = 3'b010;
        use_sel = 1'b1;
        rc(3'h3, 8'hff, 8'hb5, "summary");
        test_done();
    end
endmodule // tb
`default_nettype wire
